/* rtl/lcdftc_pkg.sv */
package lcdftc_pkg;

   localparam logic [7:0] DRIVE_CFG_OFS    = 8'hE5;
   localparam logic [7:0] FRAME_RATE_OFS   = 8'hE6;
   localparam logic [7:0] STATUS_OFS       = 8'hE8;

   localparam logic [7:0] DRIVE_CFG_RST    = 8'h00;
   localparam logic [7:0] FRAME_RATE_RST   = 8'h00;
   localparam logic [7:0] DRIVE_CFG_WMASK  = 8'hF7;
   localparam logic [7:0] FRAME_RATE_WMASK = 8'h77;

   localparam int CS_BIT        = 7;
   localparam int HALF_BIAS_BIT = 6;
   localparam int DUTY_LSB      = 4;
   localparam int RSVD_CFG_BIT  = 3;
   localparam int PM_LSB        = 0;
   localparam int RSVD_FRR_BIT  = 7;
   localparam int PS_LSB        = 4;
   localparam int RSVD_CD_BIT   = 3;
   localparam int CD_LSB        = 0;
   localparam int ST_ACTIVE_BIT = 7;

   localparam int PRE_W_MIN     = 12;
   localparam int SEG_N_MAX     = 25;
   localparam int COM_N         = 4;

   localparam logic [3:0] K_DEFAULT = 4'h8;
   localparam logic [3:0] K_THIRD   = 4'h6;

   typedef enum logic [1:0] {
      DUTY_STATIC,
      DUTY_HALF,
      DUTY_THIRD,
      DUTY_QUARTER
   } lcdftc_duty_e;

   typedef enum logic [1:0] {
      BIAS_STATIC,
      BIAS_HALF,
      BIAS_THIRD
   } lcdftc_bias_e;

   // low bits of the prescaler that must all be one at the selected tap
   function automatic logic [11:0] tap_mask(input logic [2:0] sel);
      unique case (sel)
         3'h0: tap_mask = 12'h00F;
         3'h1: tap_mask = 12'h03F;
         3'h2: tap_mask = 12'h07F;
         3'h3: tap_mask = 12'h0FF;
         3'h4: tap_mask = 12'h1FF;
         3'h5: tap_mask = 12'h3FF;
         3'h6: tap_mask = 12'h7FF;
         3'h7: tap_mask = 12'hFFF;
      endcase
   endfunction : tap_mask

   function automatic logic [3:0] k_of_duty(input lcdftc_duty_e duty);
      k_of_duty = (duty == DUTY_THIRD) ? K_THIRD : K_DEFAULT;
   endfunction : k_of_duty

   function automatic logic [4:0] seg_count(input logic [2:0] pm);
      unique case (pm)
         3'h0: seg_count = 5'h0D;
         3'h1: seg_count = 5'h0F;
         3'h2: seg_count = 5'h11;
         3'h3: seg_count = 5'h13;
         3'h4: seg_count = 5'h15;
         3'h5: seg_count = 5'h17;
         3'h6: seg_count = 5'h18;
         3'h7: seg_count = 5'h19;
      endcase
   endfunction : seg_count

   function automatic logic [3:0] com_mask(input lcdftc_duty_e duty);
      unique case (duty)
         DUTY_STATIC:  com_mask = 4'h1;
         DUTY_HALF:    com_mask = 4'h3;
         DUTY_THIRD:   com_mask = 4'h7;
         DUTY_QUARTER: com_mask = 4'hF;
      endcase
   endfunction : com_mask

endpackage : lcdftc_pkg

/* rtl/lcdftc_prescaler.sv */
`timescale 1ns/1ps
module lcdftc_prescaler import lcdftc_pkg::*; #(
   parameter int PRE_W = 12
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             enable_i,
   input  wire logic             src_tick_i,
   input  wire logic [2:0]       tap_sel_i,
   input  wire logic [2:0]       div_sel_i,
   output logic      [PRE_W-1:0] pre_count_o,
   output logic                  ps_tick_o
);

   if (PRE_W < PRE_W_MIN) begin : g_bad_width
      $error("prescaler narrower than the widest tap");
   end

   logic [PRE_W-1:0] pre_cnt_reg;
   logic             tap_reg;
   logic [2:0]       div_cnt_reg;
   logic             ps_reg;
   logic [PRE_W-1:0] mask;

   assign mask        = PRE_W'(tap_mask(tap_sel_i));
   assign pre_count_o = pre_cnt_reg;
   assign ps_tick_o   = ps_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !enable_i) begin
         pre_cnt_reg <= '0;
      end else if (src_tick_i) begin
         pre_cnt_reg <= pre_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !enable_i) begin
         tap_reg <= 1'b0;
      end else begin
         tap_reg <= src_tick_i && ((pre_cnt_reg & mask) == mask);
      end
   end

   // >= so that lowering the divide field never leaves the divider stuck
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !enable_i) begin
         div_cnt_reg <= 3'h0;
         ps_reg      <= 1'b0;
      end else if (tap_reg && div_cnt_reg >= div_sel_i) begin
         div_cnt_reg <= 3'h0;
         ps_reg      <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 3'(tap_reg);
         ps_reg      <= 1'b0;
      end
   end

endmodule : lcdftc_prescaler

/* rtl/lcdftc_frame_counter.sv */
`timescale 1ns/1ps
module lcdftc_frame_counter import lcdftc_pkg::*; (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         enable_i,
   input  wire logic         ps_tick_i,
   input  wire lcdftc_duty_e duty_i,
   output logic       [2:0]  phase_o,
   output logic              frame_o
);

   logic [2:0] phase_reg;
   logic       frame_reg;
   logic [3:0] k_val;
   logic       last;

   assign k_val   = k_of_duty(duty_i);
   assign last    = {1'b0, phase_reg} >= (k_val - 4'h1);
   assign phase_o = phase_reg;
   assign frame_o = frame_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !enable_i) begin
         phase_reg <= 3'h0;
      end else if (ps_tick_i) begin
         phase_reg <= last ? 3'h0 : phase_reg + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !enable_i) begin
         frame_reg <= 1'b0;
      end else begin
         frame_reg <= ps_tick_i && last;
      end
   end

endmodule : lcdftc_frame_counter

/* rtl/lcdftc_top.sv */
// What this block does
// - clock select bit picks system or async
// - async source: oscillator or external clock input
// - bias bit: zero third, one half bias
// - duty field sets one to four commons
// - unused common terminals return to port
// - static duty forces static bias
// - port mask sets 13 to 25 segments
// - unmasked segment terminals stay port pins
// - prescaler tap divides by 16 to 4096
// - divide field divides by value plus one
// - divided tap output is prescaled clock
// - frame rate is source over K*N*D
// - reserved bits ignore writes, read zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module lcdftc_top import lcdftc_pkg::*; #(
   parameter int PRE_W = 12,
   parameter int SEG_N = 25
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [7:0]        reg_rdata_o,
   input  wire logic              lcd_enable_bit_i,
   input  wire logic              external_clock_select_i,
   input  wire logic              timer_osc_tick_i,
   input  wire logic              ext_clock_tick_i,
   output logic                   prescaled_lcd_clock_o,
   output logic                   frame_start_o,
   output lcdftc_bias_e           bias_mode_o,
   output logic      [COM_N-1:0]  common_terminals_en_o,
   output logic      [SEG_N-1:0]  segment_terminals_en_o
);

   if (SEG_N != SEG_N_MAX) begin : g_bad_seg
      $error("segment count must match the port mask table");
   end

   logic [7:0]       drive_cfg_reg;
   logic [7:0]       frame_rate_reg;
   logic [7:0]       rdata_reg;
   lcdftc_bias_e     bias_reg;
   logic [COM_N-1:0] com_en_reg;
   logic [SEG_N-1:0] seg_en_reg;

   logic             cs;
   logic             half_bias;
   lcdftc_duty_e     duty;
   logic [2:0]       pm;
   logic [2:0]       ps_sel;
   logic [2:0]       cd_sel;
   logic             lcd_source_clock;
   logic [PRE_W-1:0] pre_count;
   logic             ps_tick;
   logic             frame_tick;
   logic [2:0]       phase;
   logic             wr_cfg;
   logic             wr_frr;

   assign cs        = drive_cfg_reg[CS_BIT];
   assign half_bias = drive_cfg_reg[HALF_BIAS_BIT];
   assign duty      = lcdftc_duty_e'(drive_cfg_reg[DUTY_LSB +: 2]);
   assign pm        = drive_cfg_reg[PM_LSB +: 3];
   assign ps_sel    = frame_rate_reg[PS_LSB +: 3];
   assign cd_sel    = frame_rate_reg[CD_LSB +: 3];
   assign wr_cfg    = reg_wr_i && reg_addr_i == DRIVE_CFG_OFS;
   assign wr_frr    = reg_wr_i && reg_addr_i == FRAME_RATE_OFS;

   // one tick per edge of the chosen source; the async ticks arrive already
   // in this domain, so the source can never run faster than the system clock
   always_comb begin
      if (!cs) begin
         lcd_source_clock = 1'b1;
      end else if (external_clock_select_i) begin
         lcd_source_clock = ext_clock_tick_i;
      end else begin
         lcd_source_clock = timer_osc_tick_i;
      end
   end

   // settings act at once; the driver is expected to be off while they change
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         drive_cfg_reg <= DRIVE_CFG_RST;
      end else if (wr_cfg) begin
         drive_cfg_reg <= reg_wdata_i & DRIVE_CFG_WMASK;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         frame_rate_reg <= FRAME_RATE_RST;
      end else if (wr_frr) begin
         frame_rate_reg <= reg_wdata_i & FRAME_RATE_WMASK;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !reg_rd_i) begin
         rdata_reg <= 8'h00;
      end else begin
         unique case (reg_addr_i)
            DRIVE_CFG_OFS:  rdata_reg <= drive_cfg_reg;
            FRAME_RATE_OFS: rdata_reg <= frame_rate_reg;
            STATUS_OFS:     rdata_reg <= {lcd_enable_bit_i, 4'h0, phase};
            default:        rdata_reg <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_o = rdata_reg;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bias_reg <= BIAS_STATIC;
      end else if (duty == DUTY_STATIC) begin
         bias_reg <= BIAS_STATIC;
      end else begin
         bias_reg <= half_bias ? BIAS_HALF : BIAS_THIRD;
      end
   end

   // a disabled driver hands every terminal back to the port logic
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !lcd_enable_bit_i) begin
         com_en_reg <= '0;
         seg_en_reg <= '0;
      end else begin
         com_en_reg <= com_mask(duty);
         for (int i = 0; i < SEG_N; i++) begin
            seg_en_reg[i] <= i < int'(seg_count(pm));
         end
      end
   end

   assign bias_mode_o            = bias_reg;
   assign common_terminals_en_o  = com_en_reg;
   assign segment_terminals_en_o = seg_en_reg;

   lcdftc_prescaler #(
      .PRE_W (PRE_W)
   ) u_prescaler (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .enable_i    (lcd_enable_bit_i),
      .src_tick_i  (lcd_source_clock),
      .tap_sel_i   (ps_sel),
      .div_sel_i   (cd_sel),
      .pre_count_o (pre_count),
      .ps_tick_o   (ps_tick)
   );

   lcdftc_frame_counter u_frame (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .enable_i  (lcd_enable_bit_i),
      .ps_tick_i (ps_tick),
      .duty_i    (duty),
      .phase_o   (phase),
      .frame_o   (frame_tick)
   );

   assign prescaled_lcd_clock_o = ps_tick;
   assign frame_start_o         = frame_tick;

   // helper logic read only by the checks below
   logic [15:0] gap_reg;
   logic        gap_clean_reg;
   logic [3:0]  ticks_reg;
   logic        frame_clean_reg;
   logic [16:0] expect_gap;

   assign expect_gap = 17'(tap_mask(ps_sel)) * 17'(cd_sel) + 17'(tap_mask(ps_sel)) + 17'(cd_sel);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || ps_tick) begin
         gap_reg <= 16'h0000;
      end else if (gap_reg != 16'hFFFF) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !lcd_enable_bit_i || cs || wr_cfg || wr_frr) begin
         gap_clean_reg <= 1'b0;
      end else if (ps_tick) begin
         gap_clean_reg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !lcd_enable_bit_i || frame_tick) begin
         ticks_reg <= 4'h0;
      end else if (ps_tick) begin
         ticks_reg <= ticks_reg + 4'h1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || !lcd_enable_bit_i || wr_cfg) begin
         frame_clean_reg <= 1'b0;
      end else if (frame_tick) begin
         frame_clean_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_cfg_read;
      reg_rd_i && reg_addr_i == DRIVE_CFG_OFS;
   endsequence

   sequence seq_frr_read;
      reg_rd_i && reg_addr_i == FRAME_RATE_OFS;
   endsequence

   sequence seq_enable_rise;
      !lcd_enable_bit_i ##1 lcd_enable_bit_i;
   endsequence

   sequence seq_status_read;
      reg_rd_i && reg_addr_i == STATUS_OFS;
   endsequence

   AST_SYS_SOURCE: assert property (
      !cs |-> lcd_source_clock)
      else $error("system clock source not ticking every cycle");

   AST_ASYNC_SOURCE: assert property (
      cs |-> lcd_source_clock == (external_clock_select_i ? ext_clock_tick_i : timer_osc_tick_i))
      else $error("async source does not follow the external select");

   AST_BIAS: assert property (
      duty != DUTY_STATIC && $stable(drive_cfg_reg)
      |=> bias_mode_o == ($past(half_bias) ? BIAS_HALF : BIAS_THIRD))
      else $error("bias does not follow the half bias bit");

   AST_STATIC_BIAS: assert property (
      duty == DUTY_STATIC |=> bias_mode_o == BIAS_STATIC)
      else $error("static duty without static bias");

   AST_COMMONS: assert property (
      lcd_enable_bit_i |=> common_terminals_en_o == com_mask($past(duty)))
      else $error("common terminals do not match duty");

   AST_COM_RELEASE: assert property (
      !lcd_enable_bit_i |=> common_terminals_en_o == '0 && segment_terminals_en_o == '0)
      else $error("terminals held while driver disabled");

   AST_SEGMENTS: assert property (
      lcd_enable_bit_i |=> $countones(segment_terminals_en_o) == int'(seg_count($past(pm))))
      else $error("segment count does not match port mask");

   AST_SEG_LOW_FIRST: assert property (
      lcd_enable_bit_i |=> segment_terminals_en_o[0]
      && (segment_terminals_en_o & (segment_terminals_en_o + 1'b1)) == '0
      && segment_terminals_en_o[SEG_N-1] == ($past(pm) == 3'h7))
      else $error("segment terminals not counted from zero");

   AST_PS_PERIOD: assert property (
      ps_tick && gap_clean_reg |-> 17'(gap_reg) == expect_gap)
      else $error("prescaled clock period differs from tap times divide");

   AST_FRAME_K: assert property (
      frame_tick && frame_clean_reg |-> ticks_reg == k_of_duty(duty))
      else $error("frame length differs from K prescaled clocks");

   AST_FRAME_ON_TICK: assert property (
      frame_tick |-> $past(ps_tick))
      else $error("frame mark without a prescaled clock");

   AST_DIV_SPACING: assert property (
      ps_tick |=> !ps_tick [*8])
      else $error("prescaled clock ticks too close");

   AST_HOLD_ZERO: assert property (
      !lcd_enable_bit_i |=> pre_count == '0 && !ps_tick && !frame_tick)
      else $error("counters run while disabled");

   AST_RESTART: assert property (
      seq_enable_rise |-> pre_count == '0 ##1 pre_count <= PRE_W'(1))
      else $error("prescaler did not restart from zero");

   AST_RSVD_CFG: assert property (
      seq_cfg_read |=> !reg_rdata_o[RSVD_CFG_BIT])
      else $error("reserved drive config bit reads one");

   AST_RSVD_FRR: assert property (
      seq_frr_read |=> !reg_rdata_o[RSVD_FRR_BIT] && !reg_rdata_o[RSVD_CD_BIT])
      else $error("reserved frame rate bit reads one");

   AST_RSVD_HELD: assert property (
      !drive_cfg_reg[RSVD_CFG_BIT] && !frame_rate_reg[RSVD_FRR_BIT] && !frame_rate_reg[RSVD_CD_BIT])
      else $error("reserved bit stored");

   // with the system source the count has moved two past the tap when the pulse leaves
   AST_TAP_ALIGN: assert property (
      ps_tick && gap_clean_reg |-> (pre_count & PRE_W'(tap_mask(ps_sel))) == PRE_W'(1))
      else $error("prescaled clock not aligned to the selected tap");

   AST_PHASE_RANGE: assert property (
      lcd_enable_bit_i && frame_clean_reg |-> {1'b0, phase} < k_of_duty(duty))
      else $error("frame phase beyond K");

   AST_FRAME_PHASE_ZERO: assert property (
      frame_tick |-> phase == 3'h0)
      else $error("frame mark while phase not restarted");

   AST_TICK_NOT_FRAME: assert property (
      ps_tick |-> !frame_tick)
      else $error("frame mark beside a prescaled clock");

   AST_THIRD_K: assert property (
      frame_tick && frame_clean_reg && duty == DUTY_THIRD |-> ticks_reg == K_THIRD)
      else $error("third duty frame not six prescaled clocks");

   AST_STATUS_ENABLE: assert property (
      seq_status_read |=> reg_rdata_o[ST_ACTIVE_BIT] == $past(lcd_enable_bit_i))
      else $error("status does not show the enable level");

   AST_HOLD_PHASE: assert property (
      !lcd_enable_bit_i |=> phase == 3'h0)
      else $error("frame phase runs while disabled");

   AST_COM0_ALWAYS: assert property (
      lcd_enable_bit_i |=> common_terminals_en_o[0])
      else $error("first common terminal not driven");

   // the smallest mask still drives thirteen segments
   AST_SEG_MIN: assert property (
      lcd_enable_bit_i |=> &segment_terminals_en_o[12:0])
      else $error("fewer segments than the smallest mask");

   AST_SEG_MAX: assert property (
      lcd_enable_bit_i && pm != 3'h7 |=> !segment_terminals_en_o[SEG_N-1])
      else $error("last segment taken from the port");

endmodule : lcdftc_top

/* verification/lcdftc_osc_model.sv */
`timescale 1ns/1ps
module lcdftc_osc_model #(
   parameter int OSC_PERIOD = 3,
   parameter int EXT_PERIOD = 5
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   output logic      timer_osc_tick_o,
   output logic      ext_clock_tick_o
);
   int osc_cnt;
   int ext_cnt;

   // both sources run free; ticks are one-cycle pulses, slower than the system clock
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         osc_cnt          <= 0;
         ext_cnt          <= 0;
         timer_osc_tick_o <= 1'b0;
         ext_clock_tick_o <= 1'b0;
      end else begin
         osc_cnt          <= (osc_cnt == OSC_PERIOD - 1) ? 0 : osc_cnt + 1;
         ext_cnt          <= (ext_cnt == EXT_PERIOD - 1) ? 0 : ext_cnt + 1;
         timer_osc_tick_o <= (osc_cnt == OSC_PERIOD - 1);
         ext_clock_tick_o <= (ext_cnt == EXT_PERIOD - 1);
      end
   end
endmodule : lcdftc_osc_model

/* verification/lcdftc_top_test.sv */
`timescale 1ns/1ps
module lcdftc_top_test import lcdftc_pkg::*; ;
   localparam int LIMIT = 5000;
   localparam int OSC_P = 3;
   localparam int EXT_P = 5;
   logic         clk;
   logic         rst_n;
   logic [7:0]   addr;
   logic [7:0]   wdata;
   logic         wr_s;
   logic         rd_s;
   logic [7:0]   rdata;
   logic         en;
   logic         ext_sel;
   logic         osc_tick;
   logic         ext_tick;
   logic         ps;
   logic         frm;
   lcdftc_bias_e bias;
   logic [3:0]   com;
   logic [24:0]  seg;
   int           bad_count;
   int           checks_done;
   int           tap_n [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
   int           seg_n [8] = '{13, 15, 17, 19, 21, 23, 24, 25};

   lcdftc_top dut_u (
      .ref_clk_i               (clk),
      .rst_n_i                 (rst_n),
      .reg_addr_i              (addr),
      .reg_wdata_i             (wdata),
      .reg_wr_i                (wr_s),
      .reg_rd_i                (rd_s),
      .reg_rdata_o             (rdata),
      .lcd_enable_bit_i        (en),
      .external_clock_select_i (ext_sel),
      .timer_osc_tick_i        (osc_tick),
      .ext_clock_tick_i        (ext_tick),
      .prescaled_lcd_clock_o   (ps),
      .frame_start_o           (frm),
      .bias_mode_o             (bias),
      .common_terminals_en_o   (com),
      .segment_terminals_en_o  (seg)
   );

   lcdftc_osc_model #(.OSC_PERIOD(OSC_P), .EXT_PERIOD(EXT_P)) osc_u (
      .ref_clk_i        (clk),
      .rst_n_i          (rst_n),
      .timer_osc_tick_o (osc_tick),
      .ext_clock_tick_o (ext_tick)
   );

   always #25 clk = ~clk;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd

   // the driver must be off while its clock, duty and mask change
   task automatic setup(input logic [7:0] cfg, input logic [7:0] frr);
      @(posedge clk);
      en <= 1'b0;
      wr(DRIVE_CFG_OFS, cfg);
      wr(FRAME_RATE_OFS, frr);
      @(posedge clk);
      en <= 1'b1;
   endtask : setup

   task automatic wait_evt(input bit on_frame, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((on_frame ? frm : ps) !== 1'b1 && n < LIMIT);
      if (n >= LIMIT) begin
         bad_count++;
         $display("[FAIL] pulse wait expected 1 seen 0");
         wrap_up();
      end
   endtask : wait_evt

   task automatic test_regs();
      logic [7:0] d;
      rd(DRIVE_CFG_OFS, d);
      check_val("drive cfg reset", 32'h00, d);
      rd(FRAME_RATE_OFS, d);
      check_val("frame rate reset", 32'h00, d);
      wr(DRIVE_CFG_OFS, 8'hFF);
      wr(FRAME_RATE_OFS, 8'hFF);
      wr(8'h10, 8'h00);
      rd(DRIVE_CFG_OFS, d);
      check_val("drive cfg reserved", 32'hF7, d);
      rd(FRAME_RATE_OFS, d);
      check_val("frame rate reserved", 32'h77, d);
      rd(8'h10, d);
      check_val("unmapped read", 32'h00, d);
   endtask : test_regs

   task automatic test_duty();
      lcdftc_bias_e b_exp;
      for (int d = 0; d < 4; d++) begin
         for (int b = 0; b < 2; b++) begin
            setup({1'b0, b[0], d[1:0], 1'b0, 3'h7}, 8'h00);
            repeat (3) @(negedge clk);
            b_exp = (d == 0) ? BIAS_STATIC : ((b == 1) ? BIAS_HALF : BIAS_THIRD);
            check_val("bias mode", {30'h0, b_exp}, {30'h0, bias});
            check_val("common enables", (32'h1 << (d + 1)) - 1, {28'h0, com});
         end
      end
   endtask : test_duty

   task automatic test_mask();
      for (int p = 0; p < 8; p++) begin
         setup({4'h3, 1'b0, p[2:0]}, 8'h00);
         repeat (3) @(negedge clk);
         check_val("segment enables", (32'h1 << seg_n[p]) - 1, {7'h0, seg});
      end
   endtask : test_mask

   task automatic test_rate();
      int n;
      for (int t = 0; t < 8; t++) begin
         setup(8'h00, {1'b0, t[2:0], 4'h0});
         wait_evt(1'b0, n);
         wait_evt(1'b0, n);
         check_val("tap period", tap_n[t], n);
      end
      for (int c = 0; c < 8; c++) begin
         setup(8'h00, {5'h00, c[2:0]});
         wait_evt(1'b0, n);
         wait_evt(1'b0, n);
         check_val("divide period", 16 * (c + 1), n);
      end
   endtask : test_rate

   task automatic test_frame();
      int k_tab [4] = '{8, 8, 6, 8};
      int p;
      int c;
      for (int d = 0; d < 4; d++) begin
         setup({2'b00, d[1:0], 4'h7}, 8'h01);
         wait_evt(1'b1, c);
         p = 0;
         c = 0;
         do begin
            @(negedge clk);
            c++;
            if (ps === 1'b1) p++;
         end while (frm !== 1'b1 && c < LIMIT);
         check_val("pulses per frame", k_tab[d], p);
         check_val("cycles per frame", k_tab[d] * 16 * 2, c);
         if (c >= LIMIT) begin
            wrap_up();
         end
      end
   endtask : test_frame

   task automatic test_async();
      int n;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         en      <= 1'b0;
         ext_sel <= s[0];
         setup(8'h80, 8'h00);
         wait_evt(1'b0, n);
         wait_evt(1'b0, n);
         check_val("async period", 16 * ((s == 1) ? EXT_P : OSC_P), n);
      end
   endtask : test_async

   task automatic test_disable();
      logic [7:0] d;
      int         n;
      setup(8'h37, 8'h00);
      wait_evt(1'b0, n);
      rd(STATUS_OFS, d);
      check_val("status enabled", 32'h80, {24'h0, d & 8'h80});
      @(posedge clk);
      en <= 1'b0;
      n = 0;
      repeat (40) begin
         @(negedge clk);
         if (ps === 1'b1 || frm === 1'b1) n++;
      end
      check_val("pulses while disabled", 32'h0, n);
      check_val("commons while disabled", 32'h0, {28'h0, com});
      rd(STATUS_OFS, d);
      check_val("status disabled", 32'h00, d);
   endtask : test_disable

   initial begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      addr        = 8'h00;
      wdata       = 8'h00;
      wr_s        = 1'b0;
      rd_s        = 1'b0;
      en          = 1'b0;
      ext_sel     = 1'b0;
      bad_count   = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      test_regs();
      test_duty();
      test_mask();
      test_rate();
      test_frame();
      test_async();
      test_disable();
      wrap_up();
   end
endmodule : lcdftc_top_test
